/* logic/mcpd_pkg.sv */
// constants and mode types for the macrocell and power-down model
// assumes a single 50 MHz system clock samples every pin
package mcpd_pkg;
	localparam int MC_COUNT = 128; // macrocells feeding the global bus
	localparam int SIGNAL_PINS = 84; // input and i/o pins on the global bus
	localparam int MATRIX_IN = 40; // switch matrix outputs per logic block
	localparam int REGION_MC = 16; // macrocells sharing one foldback bus
	localparam int LOCAL_PT = 5; // product terms local to the sum gate
	localparam int SUM_PT_MAX = 21; // widest sum reachable with foldback
	localparam int CLK_PERIOD_NS = 20;
	localparam int PD_WAKE_NS = 1000; // power-down exit to valid outputs
	localparam int PD_WAKE_CYC = PD_WAKE_NS / CLK_PERIOD_NS;
	localparam int PIN_GCLK = 0; // positions in the synchronised pin vector
	localparam int PIN_GCLR = 1;
	localparam int PIN_OE1 = 2;
	localparam int PIN_OE2 = 3;
	localparam int PIN_PD1 = 4;
	localparam int PIN_PD2 = 5;
	localparam int PIN_PAD = 6;
	localparam int PIN_EXT = 7;
	localparam int PIN_IO = 8;
	localparam logic STATE_RST = 1'h0;
	localparam logic PAD_OUT_RST = 1'h0;
	localparam logic PAD_OE_RST = 1'h0;
	localparam logic KEEP_RST = 1'h0;

	typedef enum logic [2:0] {MCPD_FF_D, MCPD_FF_T, MCPD_FF_JK, MCPD_FF_SR, MCPD_FF_LATCH} mcpd_ff_mode_type;
	typedef enum logic [1:0] {MCPD_D_XOR, MCPD_D_TERM, MCPD_D_PIN} mcpd_d_src_type;
	typedef enum logic {MCPD_CLK_GLOBAL, MCPD_CLK_TERM} mcpd_clk_src_type;
	typedef enum logic [1:0] {MCPD_CLR_OFF, MCPD_CLR_PIN, MCPD_CLR_TERM, MCPD_CLR_OR} mcpd_clr_src_type;
	typedef enum logic [2:0] {MCPD_OE_PIN1, MCPD_OE_PIN1_N, MCPD_OE_PIN2, MCPD_OE_PIN2_N, MCPD_OE_IO,
		MCPD_OE_MC} mcpd_oe_src_type;
	typedef enum logic [1:0] {MCPD_IO_INPUT, MCPD_IO_OUTPUT, MCPD_IO_BIDIR} mcpd_io_mode_type;
endpackage : mcpd_pkg

/* logic/mcpd_macrocell.sv */
// one programmable macrocell with its pin, switch matrix slice and power-down hold
// assumes pins are asynchronous to clk and product terms come from logic on clk
module mcpd_macrocell
	import mcpd_pkg::*;
#(
	parameter int BUS_W = MC_COUNT + SIGNAL_PINS,
	parameter int OE_SUB = 8
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire mcpd_pkg::mcpd_ff_mode_type cfg_ff_mode, // storage element mode
	input wire mcpd_pkg::mcpd_d_src_type cfg_d_src, // data input source
	input wire mcpd_pkg::mcpd_clk_src_type cfg_clk_src, // clock source
	input wire logic cfg_ce_use, // clock enable term in use
	input wire mcpd_pkg::mcpd_clr_src_type cfg_clr_src, // clear source
	input wire logic cfg_preset_use, // preset term in use
	input wire logic cfg_out_reg, // pin output registered
	input wire logic cfg_fb_reg, // buried feedback registered
	input wire mcpd_pkg::mcpd_oe_src_type cfg_oe_src, // output enable source
	input wire logic [$clog2(OE_SUB)-1:0] cfg_oe_idx, // subset index
	input wire mcpd_pkg::mcpd_io_mode_type cfg_io_mode, // pin direction
	input wire logic cfg_open_coll, // open collector output
	input wire logic cfg_keeper, // pin keeper on
	input wire logic cfg_pd_enable, // power-down feature on
	input wire logic [mcpd_pkg::REGION_MC-1:0] cfg_fold_use, // foldback terms summed
	input wire logic global_clock_pin, // global clock pin
	input wire logic global_clear_pin, // global clear pin
	input wire logic oe_pin_one, // global oe pin 1
	input wire logic oe_pin_two, // global oe pin 2
	input wire logic power_down_pin_one, // power-down pin 1
	input wire logic power_down_pin_two, // power-down pin 2
	input wire logic [OE_SUB-1:0] oe_io_pins, // oe subset of i/o pins
	input wire logic pad_in, // level seen on own pin
	input wire logic pad_ext_drive, // another party drives own pin
	input wire logic [mcpd_pkg::LOCAL_PT-1:0] pt_sum, // local sum terms
	input wire logic pt_xor, // xor operand term
	input wire logic pt_data, // separate data term
	input wire logic pt_aux, // k or r term
	input wire logic pt_clock, // per-cell clock term
	input wire logic pt_clk_en, // clock enable term
	input wire logic pt_clear, // clear term
	input wire logic pt_preset, // preset term
	input wire logic pt_fold, // term folded back inverted
	input wire logic [mcpd_pkg::REGION_MC-1:0] regional_fold_bus, // foldback bus
	input wire logic [OE_SUB-1:0] oe_mc, // oe subset of macrocells
	input wire logic [BUS_W-1:0] global_bus, // pins and buried feedback
	input wire logic [mcpd_pkg::MATRIX_IN*$clog2(BUS_W)-1:0] sw_sel, // matrix selects
	output logic [mcpd_pkg::MATRIX_IN-1:0] block_in, // logic block inputs
	output logic pad_out, // pin drive value
	output logic pad_oe, // pin driven
	output logic feedback_out, // buried feedback
	output logic fold_out, // foldback term
	output logic pd_active // power-down in force
);
	import mcpd_pkg::*;

	localparam int SEL_W = $clog2(BUS_W);
	localparam int PW = PIN_IO + OE_SUB;
	localparam int HW = LOCAL_PT + 8 + REGION_MC + 2 * OE_SUB + 6;
	localparam int WAKE_LIM = PD_WAKE_CYC;

	// subset index must cover the subset exactly, wake bound must fit a delay range
	if (OE_SUB < 2 || (OE_SUB & (OE_SUB - 1)) != 0 || BUS_W < 2 || LOCAL_PT + REGION_MC > SUM_PT_MAX
		|| PD_WAKE_CYC < 1 || PD_WAKE_CYC > 1000) begin : g_param_check
		$error("mcpd_macrocell: unsupported parameters");
	end

	logic [PW-1:0] pin_s1_ff, pin_s2_ff;
	logic [HW-1:0] now_vec, hold_ff, use_vec;
	logic [LOCAL_PT-1:0] u_sum;
	logic [REGION_MC-1:0] u_region;
	logic [OE_SUB-1:0] u_oemc, u_iopins;
	logic u_xor, u_data, u_aux, u_ptclk, u_ce, u_clr, u_pre, u_fold;
	logic u_ext, u_pad, u_oe2, u_oe1, u_gclr, u_gclk;
	logic state_ff, nxt_state, clk_prev_ff, keep_ff;
	logic sel_clk, clk_rise, ce_ok, clr_act, pre_act, q_now;
	logic sum_val, xor_out, d_in, out_val, fb_val, oe_sel, oe_final, pad_seen;

	// pins cross into clk through two flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {oe_io_pins, pad_ext_drive, pad_in, power_down_pin_two, power_down_pin_one,
				oe_pin_two, oe_pin_one, global_clear_pin, global_clock_pin};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign pd_active = cfg_pd_enable && (pin_s2_ff[PIN_PD1] || pin_s2_ff[PIN_PD2]);

	// power-down pins bypass the hold so exit is always seen
	assign now_vec = {pt_sum, pt_xor, pt_data, pt_aux, pt_clock, pt_clk_en, pt_clear, pt_preset, pt_fold,
		regional_fold_bus, oe_mc, pin_s2_ff[PW-1:PIN_PAD], pin_s2_ff[PIN_OE2:PIN_GCLK]};

	// input hold latches: frozen snapshot while powered down
	always_ff @(posedge clk) begin
		if (!rst_n)
			hold_ff <= '0;
		else if (!pd_active)
			hold_ff <= now_vec;
	end

	assign use_vec = pd_active ? hold_ff : now_vec;
	assign {u_sum, u_xor, u_data, u_aux, u_ptclk, u_ce, u_clr, u_pre, u_fold, u_region, u_oemc, u_iopins,
		u_ext, u_pad, u_oe2, u_oe1, u_gclr, u_gclk} = use_vec;

	// sum gate: local terms plus chosen foldback terms
	assign sum_val = (|u_sum) | (|(u_region & cfg_fold_use));
	assign xor_out = sum_val ^ u_xor;

	// keeper holds the last level anyone drove on the pin
	always_ff @(posedge clk) begin
		if (!rst_n)
			keep_ff <= KEEP_RST;
		else if (pad_oe)
			keep_ff <= pad_out;
		else if (pin_s2_ff[PIN_EXT])
			keep_ff <= pin_s2_ff[PIN_PAD];
	end

	// keeper supplies the level whenever no other board device drives the pin, own drive included
	assign pad_seen = (cfg_keeper && !u_ext) ? keep_ff : u_pad;

	always_comb begin
		case (cfg_d_src)
			MCPD_D_XOR: d_in = xor_out;
			MCPD_D_TERM: d_in = u_data;
			MCPD_D_PIN: d_in = pad_seen;
			default: d_in = xor_out;
		endcase
	end

	assign sel_clk = (cfg_clk_src == MCPD_CLK_TERM) ? u_ptclk : u_gclk;
	assign clk_rise = sel_clk && !clk_prev_ff;
	assign ce_ok = !(cfg_ce_use && cfg_clk_src == MCPD_CLK_GLOBAL && !u_ce);

	always_comb begin
		case (cfg_clr_src)
			MCPD_CLR_PIN: clr_act = u_gclr;
			MCPD_CLR_TERM: clr_act = u_clr;
			MCPD_CLR_OR: clr_act = u_gclr | u_clr;
			default: clr_act = 1'b0;
		endcase
	end

	assign pre_act = cfg_preset_use && u_pre;
	// clear outranks preset when both are asserted
	assign q_now = clr_act ? 1'b0 : (pre_act ? 1'b1 : state_ff);

	always_comb begin
		nxt_state = state_ff;
		if (cfg_ff_mode == MCPD_FF_LATCH) begin
			if (sel_clk && ce_ok)
				nxt_state = d_in;
		end else if (clk_rise && ce_ok) begin
			case (cfg_ff_mode)
				MCPD_FF_D: nxt_state = d_in;
				MCPD_FF_T: nxt_state = state_ff ^ d_in;
				MCPD_FF_JK: nxt_state = (d_in && !state_ff) || (!u_aux && state_ff);
				MCPD_FF_SR: nxt_state = (d_in && !u_aux) ? 1'b1 : ((u_aux && !d_in) ? 1'b0 : state_ff);
				default: nxt_state = state_ff;
			endcase
		end
		if (clr_act)
			nxt_state = 1'b0;
		else if (pre_act)
			nxt_state = 1'b1;
	end

	// storage element frozen in power-down, resumes with no reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= STATE_RST;
			clk_prev_ff <= 1'b0;
		end else if (!pd_active) begin
			state_ff <= nxt_state;
			clk_prev_ff <= sel_clk;
		end
	end

	assign out_val = cfg_out_reg ? q_now : xor_out;
	assign fb_val = cfg_fb_reg ? q_now : xor_out;

	always_comb begin
		case (cfg_oe_src)
			MCPD_OE_PIN1: oe_sel = u_oe1;
			MCPD_OE_PIN1_N: oe_sel = !u_oe1;
			MCPD_OE_PIN2: oe_sel = u_oe2;
			MCPD_OE_PIN2_N: oe_sel = !u_oe2;
			MCPD_OE_IO: oe_sel = u_iopins[cfg_oe_idx];
			MCPD_OE_MC: oe_sel = u_oemc[cfg_oe_idx];
			default: oe_sel = 1'b0;
		endcase
	end

	always_comb begin
		case (cfg_io_mode)
			MCPD_IO_INPUT: oe_final = 1'b0;
			MCPD_IO_OUTPUT: oe_final = 1'b1;
			MCPD_IO_BIDIR: oe_final = oe_sel;
			default: oe_final = 1'b0;
		endcase
		if (cfg_open_coll)
			oe_final = oe_final && !out_val;
	end

	// pin and feedback flops hold through power-down, refresh on the first edge after it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_out <= PAD_OUT_RST;
			pad_oe <= PAD_OE_RST;
			feedback_out <= STATE_RST;
			fold_out <= 1'b1;
		end else if (!pd_active) begin
			pad_out <= cfg_open_coll ? 1'b0 : out_val;
			pad_oe <= oe_final;
			feedback_out <= fb_val;
			fold_out <= !u_fold;
		end
	end

	// switch matrix slice, one selector per block input
	for (genvar g = 0; g < MATRIX_IN; g++) begin : g_matrix
		logic [SEL_W-1:0] sel;
		assign sel = sw_sel[g*SEL_W +: SEL_W];
		always_ff @(posedge clk) begin
			if (!rst_n)
				block_in[g] <= 1'b0;
			else if (!pd_active)
				block_in[g] <= (32'(sel) < BUS_W) ? global_bus[sel] : 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence pd_exit_s;
		$past(pd_active) && !pd_active;
	endsequence
	sequence out_valid_s;
		pad_out == (cfg_open_coll ? 1'b0 : $past(out_val)) && pad_oe == $past(oe_final);
	endsequence

	chk_pd_state_hold: assert property (pd_active |=> $stable(state_ff) && $stable(pad_out))
		else $error("state or output moved during power-down");
	chk_pd_oe_hold: assert property (pd_active && !pad_oe |=> !pad_oe || !pd_active)
		else $error("pin enabled during power-down");
	chk_pd_input_block: assert property (pd_active ##1 pd_active |-> use_vec == $past(use_vec))
		else $error("inputs reached logic during power-down");
	chk_pd_wake_valid: assert property (pd_exit_s |-> ##[1:WAKE_LIM] out_valid_s)
		else $error("outputs not valid after power-down exit");
	chk_d_edge_load: assert property (!pd_active && cfg_ff_mode == MCPD_FF_D && clk_rise && ce_ok
		&& !clr_act && !pre_act |=> state_ff == $past(d_in))
		else $error("d flip-flop missed its edge");
	chk_no_edge_hold: assert property (!pd_active && cfg_ff_mode != MCPD_FF_LATCH && !clk_rise
		&& !clr_act && !pre_act |=> $stable(state_ff))
		else $error("state changed without a clock edge");
	chk_ce_blocks_edge: assert property (!pd_active && cfg_ce_use && cfg_clk_src == MCPD_CLK_GLOBAL
		&& !u_ce && !clr_act && !pre_act |=> $stable(state_ff))
		else $error("edge taken with enable low");
	chk_latch_follow: assert property (!pd_active && cfg_ff_mode == MCPD_FF_LATCH && sel_clk && ce_ok
		&& !clr_act && !pre_act |=> state_ff == $past(d_in))
		else $error("latch not transparent");
	chk_toggle_mode: assert property (!pd_active && cfg_ff_mode == MCPD_FF_T && clk_rise && ce_ok
		&& d_in && !clr_act && !pre_act |=> state_ff != $past(state_ff))
		else $error("t flip-flop did not toggle");
	chk_clear_first: assert property (!pd_active && clr_act |=> state_ff == 1'b0)
		else $error("clear did not clear");
	chk_input_only: assert property (!pd_active && cfg_io_mode == MCPD_IO_INPUT |=> !pad_oe)
		else $error("input-only pin driven");
	chk_fold_invert: assert property (!pd_active |=> fold_out == !$past(u_fold))
		else $error("foldback not inverted");
	// pin flops reflect the mode of the previous cycle
	chk_open_coll_low: assert property (!$past(pd_active) && $past(cfg_open_coll) && pad_oe |-> pad_out == 1'b0)
		else $error("open collector drove high");
	chk_preset_set: assert property (!pd_active && pre_act && !clr_act |=> state_ff == 1'b1)
		else $error("preset did not set");
	chk_keeper_hold: assert property (!pad_oe && !pin_s2_ff[PIN_EXT] |=> $stable(keep_ff))
		else $error("keeper lost its level");
	chk_output_drive: assert property (!pd_active && cfg_io_mode == MCPD_IO_OUTPUT && !cfg_open_coll |=> pad_oe)
		else $error("output-only pin not driven");
endmodule : mcpd_macrocell

/* verif/mcpd_board.sv */
// board-side model of the wire on the macrocell's own pin
// assumes the bench decides when another board device drives the pin
module mcpd_board
	import mcpd_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic pad_out, // cell drive value
	input wire logic pad_oe, // cell drives pin
	input wire logic pull_up, // wired line pull-up fitted
	input wire logic ext_en, // board drives pin
	input wire logic ext_val, // board drive value
	output logic pad_in, // wire level
	output logic pad_ext_drive // board drives pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_ff = 1'h0;
	always @(posedge clk) last_ff <= pad_in;
	// a released wire shows its pull-up, else a stale level inverted every cycle
	always_comb begin
		if (ext_en) pad_in = ext_val;
		else if (pad_oe) pad_in = pad_out;
		else pad_in = pull_up ? 1'h1 : ~last_ff;
	end
	assign pad_ext_drive = ext_en;
endmodule : mcpd_board

/* verif/test_mcpd_macrocell.sv */
// self-checking bench for one macrocell with its board-side pin model
// assumes the macrocell and package in logic/, one 50 MHz clock
module test_mcpd_macrocell
	import mcpd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int k; logic [39:0] v;} mcpd_note_type;
	mcpd_note_type q[$];
	mcpd_note_type n;
	event chk_ev;
	int errors = 0, num_checks = 0;
	logic [31:0] seed = 32'h238e64b7;
	logic clk = 0, rst_n = 0, d = 0;
	mcpd_ff_mode_type ff_mode = MCPD_FF_D;
	mcpd_d_src_type d_src = MCPD_D_TERM;
	mcpd_clk_src_type clk_src = MCPD_CLK_TERM;
	mcpd_clr_src_type clr_src = MCPD_CLR_OFF;
	mcpd_oe_src_type oe_src = MCPD_OE_PIN1;
	mcpd_io_mode_type io_mode = MCPD_IO_OUTPUT;
	logic ce_use = 0, pre_use = 0, out_reg = 1, fb_reg = 1, oc = 0, keep = 0, pd_en = 0;
	logic gclk = 0, gclr = 0, oe1 = 0, oe2 = 0, pd1 = 0, pd2 = 0, ext_en = 0, ext_val = 0;
	logic [15:0] fold_use = 16'h0, fold_bus = 16'h0;
	logic [7:0] oe_io = 8'h0, oe_mc = 8'h0;
	logic [2:0] oe_idx = 3'h0;
	logic [4:0] pt_sum = 5'h0;
	logic pt_xor = 0, pt_data = 0, pt_aux = 0, pt_clock = 0, pt_ce = 0, pt_clr = 0, pt_pre = 0, pt_fold = 0;
	logic [211:0] gbus = '0;
	logic [319:0] sw_sel = '0;
	logic [39:0] block_in, exp_bi;
	logic pad_out, pad_oe, fb, fold, pd_act, pad_in, pad_xd, oe_exp;
	mcpd_macrocell u_dut (.clk(clk), .rst_n(rst_n), .cfg_ff_mode(ff_mode), .cfg_d_src(d_src),
		.cfg_clk_src(clk_src), .cfg_ce_use(ce_use), .cfg_clr_src(clr_src), .cfg_preset_use(pre_use),
		.cfg_out_reg(out_reg), .cfg_fb_reg(fb_reg), .cfg_oe_src(oe_src), .cfg_oe_idx(oe_idx),
		.cfg_io_mode(io_mode), .cfg_open_coll(oc), .cfg_keeper(keep), .cfg_pd_enable(pd_en),
		.cfg_fold_use(fold_use), .global_clock_pin(gclk), .global_clear_pin(gclr), .oe_pin_one(oe1),
		.oe_pin_two(oe2), .power_down_pin_one(pd1), .power_down_pin_two(pd2), .oe_io_pins(oe_io),
		.pad_in(pad_in), .pad_ext_drive(pad_xd), .pt_sum(pt_sum), .pt_xor(pt_xor), .pt_data(pt_data),
		.pt_aux(pt_aux), .pt_clock(pt_clock), .pt_clk_en(pt_ce), .pt_clear(pt_clr), .pt_preset(pt_pre),
		.pt_fold(pt_fold), .regional_fold_bus(fold_bus), .oe_mc(oe_mc), .global_bus(gbus),
		.sw_sel(sw_sel), .block_in(block_in), .pad_out(pad_out), .pad_oe(pad_oe), .feedback_out(fb),
		.fold_out(fold), .pd_active(pd_act));
	mcpd_board u_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(oc), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in), .pad_ext_drive(pad_xd));
	always #10 clk = ~clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic cyc(int c);
		repeat (c) @(negedge clk);
	endtask : cyc
	task automatic ex(int k, logic [39:0] v);
		q.push_back('{k, v});
		-> chk_ev;
		#1;
	endtask : ex
	task automatic tick(logic glob);
		if (glob) gclk = 1; else pt_clock = 1;
		cyc(4);
		gclk = 0;
		pt_clock = 0;
		cyc(4);
	endtask : tick
	task automatic cmp_bit(string nm, logic e, logic g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	task automatic cmp_vec(string nm, logic [39:0] e, logic [39:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_vec
	task automatic end_sim();
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial forever begin
		@(chk_ev);
		n = q.pop_front();
		case (n.k)
			0: cmp_bit("feedback_out", n.v[0], fb);
			1: cmp_bit("pad_out", n.v[0], pad_out);
			2: cmp_bit("pad_oe", n.v[0], pad_oe);
			3: cmp_bit("fold_out", n.v[0], fold);
			4: cmp_vec("block_in", n.v, block_in);
			default: cmp_bit("pd_active", n.v[0], pd_act);
		endcase
	end
	initial begin
		#(40000 * 20);
		errors++;
		end_sim();
	end
	initial begin
		cyc(10);
		ex(0, 0);
		ex(1, 0);
		ex(2, 0);
		ex(3, 1);
		ex(4, 0);
		rst_n = 1;
		cyc(2);
		for (int i = 0; i < 4; i++) begin
			d = 1'(xs() >> 7);
			pt_data = d;
			tick(0);
			ex(0, d);
			pt_data = ~d;
			cyc(3);
			ex(1, d);
		end
		for (int i = 0; i < 8; i++) begin
			ff_mode = i < 3 ? MCPD_FF_JK : i < 6 ? MCPD_FF_SR : MCPD_FF_T;
			pt_data = 1'(8'h5b >> i);
			pt_aux = 1'(8'h36 >> i);
			tick(0);
			ex(0, 40'(8'hd9 >> i));
		end
		ff_mode = MCPD_FF_D;
		clk_src = MCPD_CLK_GLOBAL;
		ce_use = 1;
		pt_data = 0;
		tick(1);
		ex(0, 1);
		pt_ce = 1;
		tick(1);
		ex(0, 0);
		pre_use = 1;
		pt_pre = 1;
		cyc(2);
		ex(0, 1);
		clr_src = MCPD_CLR_PIN;
		gclr = 1;
		cyc(4);
		ex(0, 0);
		gclr = 0;
		cyc(4);
		ex(0, 1);
		clr_src = MCPD_CLR_OR;
		pt_clr = 1;
		cyc(2);
		ex(0, 0);
		clr_src = MCPD_CLR_OFF;
		cyc(2);
		ex(0, 1);
		pre_use = 0;
		pt_clr = 0;
		ff_mode = MCPD_FF_LATCH;
		clk_src = MCPD_CLK_TERM;
		pt_clock = 1;
		cyc(3);
		ex(0, 0);
		pt_data = 1;
		cyc(3);
		ex(0, 1);
		pt_clock = 0;
		cyc(1);
		pt_data = 0;
		cyc(3);
		ex(0, 1);
		d_src = MCPD_D_XOR;
		out_reg = 0;
		pt_sum = 5'h4;
		pt_xor = 1;
		cyc(2);
		ex(1, 0);
		ex(0, 1);
		io_mode = MCPD_IO_INPUT;
		cyc(2);
		ex(2, 0);
		ex(0, 1);
		io_mode = MCPD_IO_BIDIR;
		for (int i = 0; i < 6; i++) begin
			oe_src = mcpd_oe_src_type'(i);
			{oe1, oe2, oe_io, oe_mc, oe_idx} = 21'(xs());
			oe_exp = i < 2 ? oe1 ^ i[0] : i < 4 ? oe2 ^ i[0] : i == 4 ? oe_io[oe_idx] : oe_mc[oe_idx];
			cyc(4);
			ex(2, oe_exp);
		end
		io_mode = MCPD_IO_OUTPUT;
		oc = 1;
		pt_sum = 5'h0;
		for (int v = 0; v < 2; v++) begin
			pt_xor = v[0];
			cyc(3);
			ex(2, 40'(!v));
			ex(1, 0);
		end
		oc = 0;
		for (int j = 0; j < 40; j++) sw_sel[j * 8 +: 8] = 8'(xs());
		gbus = 212'({xs(), xs(), xs(), xs(), xs(), xs(), xs()});
		pt_fold = 1'(xs() >> 3);
		for (int j = 0; j < 40; j++) exp_bi[j] = sw_sel[j * 8 +: 8] < 212 ? gbus[sw_sel[j * 8 +: 8]] : 1'h0;
		cyc(2);
		ex(4, exp_bi);
		ex(3, 40'(!pt_fold));
		ff_mode = MCPD_FF_D;
		d_src = MCPD_D_TERM;
		out_reg = 1;
		pt_data = 1;
		tick(0);
		pd_en = 1;
		pd1 = 1;
		cyc(3);
		ex(5, 1);
		io_mode = MCPD_IO_INPUT;
		pt_data = 0;
		tick(0);
		ex(0, 1);
		ex(1, 1);
		ex(2, 1);
		pd1 = 0;
		cyc(PD_WAKE_CYC);
		ex(5, 0);
		ex(2, 0);
		ex(0, 1);
		io_mode = MCPD_IO_BIDIR;
		oe_src = MCPD_OE_PIN1;
		oe1 = 0;
		cyc(4);
		ex(2, 0);
		pd2 = 1;
		cyc(3);
		ex(5, 1);
		oe1 = 1;
		cyc(4);
		ex(2, 0);
		pd2 = 0;
		cyc(4);
		ex(5, 0);
		ex(2, 1);
		io_mode = MCPD_IO_INPUT;
		d_src = MCPD_D_PIN;
		keep = 1;
		for (int v = 0; v < 2; v++) begin
			ext_en = 1;
			ext_val = v[0];
			cyc(4);
			ext_en = 0;
			cyc(4);
			tick(0);
			ex(0, 40'(v));
		end
		fb_reg = 0;
		clr_src = MCPD_CLR_TERM;
		pt_clr = 1;
		cyc(2);
		ex(0, 1);
		ex(1, 0);
		fold_use = 16'h0001;
		fold_bus = 16'h0001;
		cyc(2);
		ex(0, 0);
		end_sim();
	end
endmodule : test_mcpd_macrocell
